//--- shared/shared_four_bit_port_pkg.sv
// constants, carriers and decode helpers for the shared four-bit port
`default_nettype none
package shared_four_bit_port_pkg;

    localparam int unsigned PIN_COUNT = 4;
    localparam int unsigned REG_W     = 8;
    localparam int unsigned BUS_W     = 32;
    localparam int unsigned ADDR_MIN  = 18;
    localparam int unsigned IOC_W     = 3;

    // register indices; byte address is four times the index
    localparam logic [15:0] DIR_IDX = 16'hffd4;
    localparam logic [15:0] VAL_IDX = 16'hffd6;
    localparam logic [15:0] FN_IDX  = 16'hffd8;

    // reset and read-back values
    localparam logic [7:0]  DIR_RST  = 8'h00;
    localparam logic [7:0]  DIR_READ = 8'hff;
    localparam logic [7:0]  VAL_RST  = 8'h00;
    localparam logic [31:0] FN_RST   = 32'h0000_0000;

    // pin function register layout
    localparam int unsigned FN_PAT_LSB   = 0;
    localparam int unsigned FN_OE_LSB    = 4;
    localparam int unsigned FN_TIMER3_PWM_SELECT_BIT  = 8;
    localparam int unsigned FN_TIMER4_PWM_SELECT_BIT  = 9;
    localparam int unsigned FN_IOC_LSB   = 10;
    localparam int unsigned FN_USED_W    = 22;
    localparam int unsigned IOC_CAP_BIT  = 2;

    typedef struct packed {
        logic             out_en;
        logic             pwm;
        logic [IOC_W-1:0] io_ctrl;
    } timer_ctrl_t;

    typedef struct packed {
        logic        pattern_en;
        timer_ctrl_t tmr;
    } pin_fn_t;

    typedef enum logic [1:0] {
        ROLE_PORT_IN  = 2'b00,
        ROLE_PORT_OUT = 2'b01,
        ROLE_PATTERN  = 2'b11,
        ROLE_TIMER    = 2'b10
    } pin_role_t;

    // timer drives the pin: enabled and compare output selected, or on side A pwm selected
    function automatic logic timer_out_sel(input timer_ctrl_t c,
                                           input logic side_a);
        logic cmp;
        cmp = !c.io_ctrl[IOC_CAP_BIT] && (c.io_ctrl[1:0] != 2'b00);
        timer_out_sel = c.out_en && (cmp || (side_a && c.pwm));
    endfunction

    // pin level is routed to the timer capture input
    function automatic logic capture_sel(input timer_ctrl_t c);
        capture_sel = !c.pwm && c.io_ctrl[IOC_CAP_BIT];
    endfunction

    function automatic logic [ADDR_MIN-1:0] reg_addr(input logic [15:0] i);
        reg_addr = {i, 2'b00};
    endfunction

endpackage
`default_nettype wire

//--- src/port_apb_decode.sv
// apb address decode and strobes for the shared four-bit port
`default_nettype none
module port_apb_decode #(
    parameter int unsigned ADDR_W = 18
) (
    // apb request
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [ADDR_W-1:0] paddr_i,
    // decoded
    output logic                   hit_dir_o,
    output logic                   hit_val_o,
    output logic                   hit_fn_o,
    output logic                   setup_o,
    output logic                   wr_stb_o,
    output logic                   err_o
);
    logic mapped;

    assign hit_dir_o = paddr_i ==
        ADDR_W'(shared_four_bit_port_pkg::reg_addr(
            shared_four_bit_port_pkg::DIR_IDX));
    assign hit_val_o = paddr_i ==
        ADDR_W'(shared_four_bit_port_pkg::reg_addr(
            shared_four_bit_port_pkg::VAL_IDX));
    assign hit_fn_o  = paddr_i ==
        ADDR_W'(shared_four_bit_port_pkg::reg_addr(
            shared_four_bit_port_pkg::FN_IDX));
    assign mapped    = hit_dir_o || hit_val_o || hit_fn_o;
    assign setup_o   = psel_i && !penable_i;
    // pready is always high, so the access cycle completes the transfer
    assign wr_stb_o  = psel_i && penable_i && pwrite_i && mapped;
    assign err_o     = psel_i && penable_i && !mapped;
endmodule
`default_nettype wire

//--- src/port_pin_mux.sv
// function selection for one shared port pin
`default_nettype none
module port_pin_mux #(
    parameter bit SIDE_A = 1'b0
) (
    // configuration
    input  wire shared_four_bit_port_pkg::pin_fn_t fn_i,
    input  wire logic                              dir_i,
    input  wire logic                              val_i,
    // sources
    input  wire logic                              pattern_i,
    input  wire logic                              timer_i,
    // result
    output logic                                   drive_o,
    output logic                                   drive_en_o,
    output logic                                   capture_en_o,
    output shared_four_bit_port_pkg::pin_role_t    role_o
);
    always_comb begin
        // timer output wins over direction and pattern
        if (shared_four_bit_port_pkg::timer_out_sel(fn_i.tmr, SIDE_A)) begin
            role_o = shared_four_bit_port_pkg::ROLE_TIMER;
        end else if (!dir_i) begin
            role_o = shared_four_bit_port_pkg::ROLE_PORT_IN;
        end else if (fn_i.pattern_en) begin
            role_o = shared_four_bit_port_pkg::ROLE_PATTERN;
        end else begin
            role_o = shared_four_bit_port_pkg::ROLE_PORT_OUT;
        end
    end

    always_comb begin
        case (role_o)
            shared_four_bit_port_pkg::ROLE_TIMER: begin
                drive_o    = timer_i;
                drive_en_o = 1'b1;
            end
            shared_four_bit_port_pkg::ROLE_PATTERN: begin
                drive_o    = pattern_i;
                drive_en_o = 1'b1;
            end
            shared_four_bit_port_pkg::ROLE_PORT_OUT: begin
                drive_o    = val_i;
                drive_en_o = 1'b1;
            end
            default: begin
                drive_o    = 1'b0;
                drive_en_o = 1'b0;
            end
        endcase
    end

    assign capture_en_o = shared_four_bit_port_pkg::capture_sel(fn_i.tmr);
endmodule
`default_nettype wire

//--- src/shared_four_bit_port.sv
// four-bit general-purpose port shared with pattern and timer pins
//
// The implementer's own choice: the APB slave port.
`default_nettype none
module shared_four_bit_port #(
    parameter int unsigned ADDR_W = 18
) (
    // clock and reset
    input  wire logic                   sys_clk_i,
    input  wire logic                   rst_i,
    // apb slave
    input  wire logic                   psel_i,
    input  wire logic                   penable_i,
    input  wire logic                   pwrite_i,
    input  wire logic [ADDR_W-1:0]      paddr_i,
    input  wire logic [31:0]            pwdata_i,
    input  wire logic [3:0]             pstrb_i,
    output logic [31:0]                 prdata_o,
    output logic                        pready_o,
    output logic                        pslverr_o,
    // power states
    input  wire logic                   hw_standby_i,
    input  wire logic                   sw_standby_i,
    // pattern controller and timer sources
    input  wire logic [3:0]             pattern_data_i,
    input  wire logic [3:0]             timer_out_i,
    // timer capture inputs
    output logic [3:0]                  capture_en_o,
    output logic [3:0]                  capture_level_o,
    // pins
    input  wire logic [3:0]             pin_in_i,
    output logic [3:0]                  pin_out_o,
    output logic [3:0]                  pin_oe_o
);
    localparam int unsigned N = shared_four_bit_port_pkg::PIN_COUNT;
    localparam int unsigned W = shared_four_bit_port_pkg::REG_W;

    if (ADDR_W < shared_four_bit_port_pkg::ADDR_MIN) begin : g_chk
        $error("ADDR_W too narrow for the register map");
    end

    // registers
    logic [W-1:0]   dir_q;
    logic [W-1:0]   val_q;
    logic [31:0]    fn_q;
    logic [31:0]    prdata_q;
    logic [N-1:0]   pin_out_q;
    logic [N-1:0]   pin_oe_q;
    logic [N-1:0]   cap_en_q;
    logic [N-1:0]   cap_lvl_q;

    // decode
    logic           hit_dir;
    logic           hit_val;
    logic           hit_fn;
    logic           setup;
    logic           wr_stb;
    logic           bus_err;

    // per-pin results
    shared_four_bit_port_pkg::pin_fn_t   pin_fn   [N];
    shared_four_bit_port_pkg::pin_role_t pin_role [N];
    logic [N-1:0]   drive;
    logic [N-1:0]   drive_en;
    logic [N-1:0]   cap_en;
    logic [W-1:0]   port_read;
    logic [31:0]    read_mux;

    port_apb_decode #(
        .ADDR_W (ADDR_W)
    ) u_decode (
        .psel_i    (psel_i),
        .penable_i (penable_i),
        .pwrite_i  (pwrite_i),
        .paddr_i   (paddr_i),
        .hit_dir_o (hit_dir),
        .hit_val_o (hit_val),
        .hit_fn_o  (hit_fn),
        .setup_o   (setup),
        .wr_stb_o  (wr_stb),
        .err_o     (bus_err)
    );

    // direction register
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dir_q <= shared_four_bit_port_pkg::DIR_RST;
        end else if (hw_standby_i) begin
            dir_q <= shared_four_bit_port_pkg::DIR_RST;
        end else if (wr_stb && hit_dir && pstrb_i[0]) begin
            dir_q <= pwdata_i[W-1:0];
        end
    end

    // value register, all eight bits stored
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            val_q <= shared_four_bit_port_pkg::VAL_RST;
        end else if (hw_standby_i) begin
            val_q <= shared_four_bit_port_pkg::VAL_RST;
        end else if (wr_stb && hit_val && pstrb_i[0]) begin
            val_q <= pwdata_i[W-1:0];
        end
    end

    // pin function register, byte lanes honoured
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            fn_q <= shared_four_bit_port_pkg::FN_RST;
        end else if (hw_standby_i) begin
            fn_q <= shared_four_bit_port_pkg::FN_RST;
        end else if (wr_stb && hit_fn) begin
            for (int b = 0; b < 4; b++) begin
                if (pstrb_i[b]) begin
                    fn_q[8*b +: 8] <= pwdata_i[8*b +: 8];
                end
            end
        end
    end

    // unpack function controls per pin
    always_comb begin
        for (int p = 0; p < N; p++) begin
            pin_fn[p].pattern_en =
                fn_q[shared_four_bit_port_pkg::FN_PAT_LSB + p];
            pin_fn[p].tmr.out_en =
                fn_q[shared_four_bit_port_pkg::FN_OE_LSB + p];
            pin_fn[p].tmr.io_ctrl = fn_q[
                shared_four_bit_port_pkg::FN_IOC_LSB
                + p*shared_four_bit_port_pkg::IOC_W +:
                shared_four_bit_port_pkg::IOC_W];
            // pins 0,1 belong to timer 3, pins 2,3 to timer 4
            pin_fn[p].tmr.pwm = (p < 2) ?
                fn_q[shared_four_bit_port_pkg::FN_TIMER3_PWM_SELECT_BIT] :
                fn_q[shared_four_bit_port_pkg::FN_TIMER4_PWM_SELECT_BIT];
        end
    end

    // no chip mode enters the selection
    for (genvar p = 0; p < N; p++) begin : g_pin
        port_pin_mux #(
            .SIDE_A ((p % 2) == 0)
        ) u_mux (
            .fn_i         (pin_fn[p]),
            .dir_i        (dir_q[p]),
            .val_i        (val_q[p]),
            .pattern_i    (pattern_data_i[p]),
            .timer_i      (timer_out_i[p]),
            .drive_o      (drive[p]),
            .drive_en_o   (drive_en[p]),
            .capture_en_o (cap_en[p]),
            .role_o       (pin_role[p])
        );
    end

    // pin drivers
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_out_q <= '0;
            pin_oe_q  <= '0;
        end else if (hw_standby_i) begin
            pin_out_q <= '0;
            pin_oe_q  <= '0;
        end else if (!sw_standby_i) begin
            pin_out_q <= drive;
            pin_oe_q  <= drive_en;
        end
    end

    // timer capture routing
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cap_en_q  <= '0;
            cap_lvl_q <= '0;
        // hardware standby drops capture routing with the registers
        end else if (hw_standby_i) begin
            cap_en_q  <= '0;
            cap_lvl_q <= '0;
        end else begin
            cap_en_q  <= cap_en;
            cap_lvl_q <= pin_in_i & cap_en;
        end
    end

    // port read value
    always_comb begin
        port_read = val_q;
        for (int p = 0; p < N; p++) begin
            port_read[p] = dir_q[p] ? val_q[p] : pin_in_i[p];
        end
    end

    always_comb begin
        read_mux = '0;
        if (hit_dir) begin
            read_mux[W-1:0] = shared_four_bit_port_pkg::DIR_READ;
        end else if (hit_val) begin
            read_mux[W-1:0] = port_read;
        end else if (hit_fn) begin
            read_mux[shared_four_bit_port_pkg::FN_USED_W-1:0] =
                fn_q[shared_four_bit_port_pkg::FN_USED_W-1:0];
        end
    end

    // read data captured in the setup cycle, held through the access
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            prdata_q <= '0;
        end else if (setup && !pwrite_i) begin
            prdata_q <= read_mux;
        end
    end

    assign prdata_o        = prdata_q;
    assign pready_o        = 1'b1;
    assign pslverr_o       = bus_err;
    assign pin_out_o       = pin_out_q;
    assign pin_oe_o        = pin_oe_q;
    assign capture_en_o    = cap_en_q;
    assign capture_level_o = cap_lvl_q;
endmodule
`default_nettype wire

//--- verif/pin_partner.sv
// external circuitry on the four shared port pins
`default_nettype none
module pin_partner (
    // pin drive from the port
    input  wire logic [3:0] out_i,
    input  wire logic [3:0] oe_i,
    // level the outside world drives when the port lets go
    input  wire logic [3:0] ext_i,
    // resolved pin level
    output logic [3:0]      level_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // driven pins show the port, others the outside
    assign level_o = (out_i & oe_i) | (ext_i & ~oe_i);
endmodule
`default_nettype wire

//--- verif/shared_four_bit_port_sva.sv
// concurrent checks on the shared four-bit port
`default_nettype none
module shared_four_bit_port_sva #(
    parameter int unsigned ADDR_W = 18
) (
    input wire logic              sys_clk_i,
    input wire logic              rst_i,
    input wire logic              psel_i,
    input wire logic              penable_i,
    input wire logic              pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0]       pwdata_i,
    input wire logic [3:0]        pstrb_i,
    input wire logic [31:0]       prdata_o,
    input wire logic              pready_o,
    input wire logic              pslverr_o,
    input wire logic              hw_standby_i,
    input wire logic              sw_standby_i,
    input wire logic [3:0]        pattern_data_i,
    input wire logic [3:0]        timer_out_i,
    input wire logic [3:0]        capture_en_o,
    input wire logic [3:0]        capture_level_o,
    input wire logic [3:0]        pin_in_i,
    input wire logic [3:0]        pin_out_o,
    input wire logic [3:0]        pin_oe_o
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [ADDR_W-1:0] A_DIR = ADDR_W'(18'h3ff50);
    localparam logic [ADDR_W-1:0] A_VAL = ADDR_W'(18'h3ff58);
    localparam logic [ADDR_W-1:0] A_FN  = ADDR_W'(18'h3ff60);
    logic rd_acc;
    logic mapped;
    assign rd_acc = psel_i && penable_i && !pwrite_i;
    assign mapped = paddr_i == A_DIR || paddr_i == A_VAL || paddr_i == A_FN;
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    a_dir_ones: assert property (
        rd_acc && paddr_i == A_DIR |-> prdata_o == 32'h0000_00ff)
        else $error("direction read not all ones");
    a_val_upper: assert property (
        rd_acc && paddr_i == A_VAL |-> prdata_o[31:8] == 24'h00_0000)
        else $error("value read upper bits not zero");
    a_bus_err: assert property (
        psel_i && penable_i |-> pslverr_o == !mapped)
        else $error("error response wrong for address");
    a_err_data: assert property (
        rd_acc && !mapped |-> prdata_o == 32'h0000_0000)
        else $error("unmapped read data not zero");
    a_ready_high: assert property (pready_o)
        else $error("ready low");
    a_hw_clear: assert property (
        hw_standby_i [*2] |-> pin_oe_o == 4'h0 && capture_en_o == 4'h0)
        else $error("hardware standby left pins enabled");
    a_sw_hold: assert property (
        $past(sw_standby_i) && !$past(hw_standby_i)
        |-> $stable(pin_out_o) && $stable(pin_oe_o))
        else $error("pins moved in software standby");
    a_cap_level: assert property (
        $stable(capture_en_o) && !$past(hw_standby_i)
        |-> capture_level_o == ($past(pin_in_i) & capture_en_o))
        else $error("capture level wrong");
endmodule

bind shared_four_bit_port shared_four_bit_port_sva #(
    .ADDR_W(ADDR_W)
) i_shared_four_bit_port_sva (.*);
`default_nettype wire

//--- verif/shared_four_bit_port_tb_top.sv
// register-level testbench for the shared four-bit port
`default_nettype none
module shared_four_bit_port_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [17:0] A_DIR = 18'h3ff50;
    localparam logic [17:0] A_VAL = 18'h3ff58;
    localparam logic [17:0] A_FN  = 18'h3ff60;
    logic        clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic        hw;
    logic        sw;
    logic        pready;
    logic        pslverr;
    logic        err;
    logic [17:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic [3:0]  pat;
    logic [3:0]  tmr;
    logic [3:0]  ext;
    logic [3:0]  strb;
    logic [3:0]  cap_en;
    logic [3:0]  cap_lv;
    logic [3:0]  pin_lv;
    logic [3:0]  pin_out;
    logic [3:0]  pin_oe;
    int          n_mismatch = 0;
    int          n_tests = 0;
    int          cyc = 0;

    shared_four_bit_port i_shared_four_bit_port (
        .sys_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .pstrb_i(strb), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .hw_standby_i(hw), .sw_standby_i(sw),
        .pattern_data_i(pat), .timer_out_i(tmr), .capture_en_o(cap_en),
        .capture_level_o(cap_lv), .pin_in_i(pin_lv),
        .pin_out_o(pin_out), .pin_oe_o(pin_oe));
    pin_partner i_pin_partner (
        .out_i(pin_out), .oe_i(pin_oe), .ext_i(ext), .level_o(pin_lv));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic wrap_up;
        $display("compares %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; psel stays up so a setup may follow at once
    task automatic apb(input logic wr, input logic [17:0] a,
                       input logic [31:0] wd);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // wait for the slave; only the bench timeout ends a hang
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        penable <= 1'b0;
    endtask

    task automatic wait_cy(input int n);
        psel <= 1'b0;
        repeat (n) @(posedge clk);
    endtask

    initial begin
        {rst, psel, penable, pwrite, hw, sw} <= 6'h20;
        {paddr, pwdata} <= '0;
        {pat, tmr, ext} <= '0;
        strb <= 4'hf;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(1'b0, A_VAL, 0); chk(rd, 32'h0);
        apb(1'b0, A_DIR, 0); chk(rd, 32'hff);
        wait_cy(1); chk(pin_oe, 4'h0);
        $display("test reset done");
        apb(1'b1, A_DIR, 32'h0f);
        apb(1'b1, A_VAL, 32'ha5);
        wait_cy(3);
        chk(pin_oe, 4'hf);
        chk(pin_out, 4'h5);
        apb(1'b0, A_DIR, 0); chk(rd, 32'hff);
        apb(1'b1, A_DIR, 32'h05);
        ext <= 4'ha;
        wait_cy(3); chk(pin_oe, 4'h5);
        apb(1'b0, A_VAL, 0); chk(rd, 32'haf);
        ext <= 4'h0;
        wait_cy(3);
        apb(1'b0, A_VAL, 0); chk(rd, 32'ha5);
        $display("test direction done");
        apb(1'b1, A_DIR, 32'h0f);
        apb(1'b1, A_FN, 32'h0f);
        pat <= 4'h6;
        wait_cy(3); chk(pin_out, 4'h6);
        apb(1'b0, A_VAL, 0); chk(rd, 32'ha5);
        apb(1'b1, A_FN, 32'h000924ff);
        tmr <= 4'h9;
        apb(1'b1, A_DIR, 0);
        wait_cy(3);
        chk(pin_out, 4'h9);
        chk(pin_oe, 4'hf);
        apb(1'b1, A_FN, 32'h000000f0);
        wait_cy(3); chk(pin_oe, 4'h0);
        apb(1'b1, A_FN, 32'h002490f0);
        ext <= 4'h6;
        wait_cy(3);
        chk(cap_en, 4'hf);
        chk(cap_lv, 4'h6);
        chk(pin_oe, 4'h0);
        apb(1'b1, A_FN, 32'h002493f0);
        wait_cy(3);
        chk(cap_en, 4'h0);
        chk(pin_oe, 4'h5);
        $display("test functions done");
        apb(1'b1, A_FN, 0);
        apb(1'b1, A_DIR, 32'h0f);
        apb(1'b1, A_VAL, 32'h03);
        wait_cy(3);
        sw <= 1'b1;
        wait_cy(2);
        apb(1'b1, A_VAL, 32'h0c);
        wait_cy(3); chk(pin_out, 4'h3);
        apb(1'b0, A_VAL, 0); chk(rd, 32'h0c);
        sw <= 1'b0;
        wait_cy(3);
        chk(pin_oe, 4'hf);
        chk(pin_out, 4'hc);
        $display("test software standby done");
        apb(1'b1, A_FN, 32'h00249000);
        hw  <= 1'b1;
        ext <= 4'h0;
        wait_cy(3);
        hw <= 1'b0;
        wait_cy(2);
        chk(pin_oe, 4'h0);
        chk(cap_en, 4'h0);
        apb(1'b0, A_VAL, 0); chk(rd, 32'h0);
        $display("test hardware standby done");
        // a write without byte lane 0 must leave the value register alone
        strb <= 4'he;
        apb(1'b1, A_VAL, 32'hff);
        strb <= 4'hf;
        apb(1'b0, A_VAL, 0); chk(rd, 32'h0);
        $display("test byte lanes done");
        apb(1'b0, 18'h3ff54, 0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        wait_cy(1);
        $display("test unmapped done");
        wrap_up();
    end
endmodule
`default_nettype wire
